// *** bench/lane_interleave_tx_path_bench.sv ***
// lane_interleave_tx_path_bench.sv - self-checking bench of the transmit path
// assumes lit_tx_path with its defaults and the far-end model lit_far_rx
`timescale 1ns/1ps
`include "lit_regs.svh"
module lane_interleave_tx_path_bench;
	import lit_pkg::*;
	// =====================================================================
	// signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0, wb_rdat;
	logic [3:0] wb_sel = 4'h0, lane_vld = 4'h0;
	logic [39:0] lane_data = 40'h0, d;
	logic hs_rdy, agg_vld, pull_go = 1'b0, pull_slow = 1'b0, pull_busy;
	logic [7:0] pull_cnt = 8'h00;
	logic ce = 1'b1;
	lit_char_t agg_data, last_word;
	logic [57:0] scr_s;
	logic [32:0] rd_q[$];
	logic [9:0] agg_q[$];
	int num_errors = 0;
	int checks = 0;

	// clock of 100 ns period
	always #50 clk = ~clk;

	lit_tx_path u_lit_tx_path (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
		.i_wb_dat(wb_dat), .i_wb_sel(wb_sel), .o_wb_ack(wb_ack), .o_wb_dat(wb_rdat),
		.i_lane_vld(lane_vld), .i_lane_data(lane_data), .i_hs_rdy(hs_rdy),
		.o_agg_data(agg_data), .o_agg_vld(agg_vld));
	lit_far_rx u_lit_far_rx (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(pull_go),
		.i_count(pull_cnt), .i_slow(pull_slow), .i_agg_vld(agg_vld),
		.i_agg_data(agg_data), .o_hs_rdy(hs_rdy), .o_busy(pull_busy), .o_last(last_word));

	// =====================================================================
	// checking
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %08h expected %08h", $time, seen, exp);
		end
	endtask
	// every ack takes the oldest bus note, reads are compared
	always @(posedge clk) begin
		logic [32:0] e;
		if (wb_ack === 1'b1) begin
			e = (rd_q.size() > 0) ? rd_q.pop_front() : {1'b1, 32'hDEAD0000};
			if (e[32]) check(wb_rdat, e[31:0]);
		end
	end
	// every aggregate word takes the oldest stream note
	always @(posedge clk) begin
		logic [31:0] e;
		if (agg_vld === 1'b1) begin
			e = (agg_q.size() > 0) ? {22'h0, agg_q.pop_front()} : 32'hDEAD0000;
			check({22'h0, agg_data}, e);
		end
	end

	// =====================================================================
	// drivers
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		rd_q.push_back({~w, v});
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= w ? v : 32'h0;
		wb_sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) num_errors++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask
	// enter config with the datapath held, then release it
	task cfg(input logic [10:0] c);
		wb(1'b1, `LIT_CTRL_OFS, {21'h0, c | 11'h001});
		wb(1'b1, `LIT_CTRL_OFS, {21'h0, c & 11'h7FE});
	endtask
	// one word on each selected lane, then the lines show the inverse
	task lanes(input logic [3:0] m, input logic [39:0] v);
		@(posedge clk);
		lane_vld <= m;
		lane_data <= v;
		@(posedge clk);
		lane_vld <= 4'h0;
		lane_data <= ~v;
	endtask
	task pull(input int n, input logic s);
		int t;
		@(posedge clk);
		pull_go <= 1'b1;
		pull_cnt <= n[7:0];
		pull_slow <= s;
		@(posedge clk);
		pull_go <= 1'b0;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pull_busy === 1'b1 && t < 200);
		if (t >= 200) num_errors++;
		repeat (2) @(posedge clk);
	endtask
	// bit j of the aggregate comes from lane j%n, bit j/n
	function automatic logic [39:0] bitmix(input logic [39:0] v, input int n);
		logic [39:0] r;
		r = 40'h0;
		for (int j = 0; j < n * 10; j++) r[j] = v[(j % n) * 10 + j / n];
		return r;
	endfunction
	// self-synchronising scrambler, msb first
	function automatic logic [9:0] scr(input logic [9:0] w);
		logic [9:0] r;
		for (int i = 9; i >= 0; i--) begin
			r[i] = w[i] ^ scr_s[`LIT_SCR_TAP_A] ^ scr_s[`LIT_SCR_TAP_B];
			scr_s = {scr_s[56:0], r[i]};
		end
		return r;
	endfunction
	task end_sim;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		void'($urandom(32'hf7f0));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, `LIT_CTRL_OFS, 32'h001);
		wb(1'b0, `LIT_ALIGN_OFS, {22'h0, `LIT_ALIGN_RST});
		wb(1'b0, `LIT_MARK_OFS, {6'h0, `LIT_REPL_RST, 6'h0, `LIT_SRCH_RST});
		wb(1'b0, `LIT_IDLE_OFS, {22'h0, `LIT_IDLE_RST});
		wb(1'b1, 8'h20, $urandom);
		wb(1'b0, 8'h20, 32'h0);
		$display("test registers done");
		// word and bit interleave over 2, 3 and 4 lanes, then an empty pull
		for (int md = 0; md < 2; md++) begin
			for (int n = 2; n <= 4; n++) begin
				cfg({4'h0, 2'(n - 2), 3'h0, md[0], 1'b0});
				for (int r = 0; r < 3; r++) begin
					d = 40'({$urandom, $urandom});
					if (r == 2) d = {4{`LIT_IDLE_RST}};
					else lanes(4'((1 << n) - 1), d);
					if (md == 1) d = bitmix(d, n);
					for (int l = 0; l < n; l++) agg_q.push_back(d[l * 10 +: 10]);
					pull(n, r[0]);
					check({22'h0, last_word}, {22'h0, d[(n - 1) * 10 +: 10]});
				end
			end
		end
		$display("test interleave done");
		// settings written outside datapath reset stay inactive
		wb(1'b1, `LIT_CTRL_OFS, 32'h0);
		wb(1'b0, `LIT_CTRL_OFS, 32'h0);
		d = 40'({$urandom, $urandom});
		lanes(4'hF, d);
		d = bitmix(d, 4);
		for (int l = 0; l < 4; l++) agg_q.push_back(d[l * 10 +: 10]);
		pull(4, 1'b0);
		$display("test shadow done");
		// lane marking with default and reprogrammed characters
		cfg(11'h400);
		lanes(4'h3, {20'h0, 10'h2AA, `LIT_SRCH_RST});
		agg_q.push_back(`LIT_REPL_RST);
		agg_q.push_back(10'h2AA);
		pull(2, 1'b0);
		wb(1'b1, `LIT_MARK_OFS, {6'h0, 10'h155, 6'h0, 10'h2AA});
		cfg(11'h400);
		lanes(4'h3, {20'h0, 10'h2AA, `LIT_SRCH_RST});
		agg_q.push_back(`LIT_SRCH_RST);
		agg_q.push_back(10'h155);
		pull(2, 1'b1);
		$display("test marking done");
		// scrambler from a cleared state
		cfg(11'h008);
		scr_s = 58'h0;
		for (int r = 0; r < 2; r++) begin
			d = 40'({$urandom, $urandom});
			lanes(4'h3, d);
			agg_q.push_back(scr(d[9:0]));
			agg_q.push_back(scr(d[19:10]));
		end
		pull(4, 1'b1);
		$display("test scrambler done");
		// alignment: known history, pattern, then lock on the next word
		lanes(4'h3, 40'h0);
		cfg(11'h080);
		for (int r = 0; r < 4; r++) lanes(4'h3, (r == 1) ? {20'h0, {2{`LIT_ALIGN_RST}}} : 40'h0);
		agg_q.push_back(`LIT_ALIGN_RST);
		agg_q.push_back(`LIT_ALIGN_RST);
		agg_q.push_back(10'h000);
		agg_q.push_back(10'h000);
		pull(4, 1'b0);
		wb(1'b0, `LIT_STAT_OFS, 32'h0000_0003);
		$display("test alignment done");
		// a lane word offered while the clock enable is low is lost
		ce <= 1'b0;
		lanes(4'h3, 40'h0);
		ce <= 1'b1;
		agg_q.push_back(`LIT_IDLE_RST);
		agg_q.push_back(`LIT_IDLE_RST);
		pull(2, 1'b0);
		$display("test clock enable done");
		// decode, then scramble-first encode: control characters skip the scrambler
		cfg(11'h11C);
		lanes(4'h3, {20'h0, 10'h0FA, 10'h305});
		agg_q.push_back(10'h0FA);
		agg_q.push_back(10'h305);
		pull(2, 1'b1);
		$display("test encoding done");
		// overflow and invalid code flags, then clearing them
		repeat (9) lanes(4'h1, 40'h0);
		wb(1'b0, `LIT_STAT_OFS, 32'h0000_1010);
		wb(1'b1, `LIT_STAT_OFS, 32'h0000_FFF0);
		wb(1'b0, `LIT_STAT_OFS, 32'h0000_0000);
		$display("test status done");
		end_sim;
	end

	// watchdog well beyond the few hundred cycles the tests take
	initial begin
		#3000000;
		num_errors++;
		$display("watchdog expired");
		end_sim;
	end
endmodule // lane_interleave_tx_path_bench

// *** bench/lit_far_rx.sv ***
// lit_far_rx.sv - far-end receiver model that pulls aggregate words
// assumes the transmit path answers each pull with o_agg_vld one edge later
`timescale 1ns/1ps
module lit_far_rx (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [7:0] i_count,
	input wire logic i_slow,
	input wire logic i_agg_vld,
	input wire lit_pkg::lit_char_t i_agg_data,
	output logic o_hs_rdy,
	output logic o_busy,
	output lit_pkg::lit_char_t o_last
);
	import lit_pkg::*;
	// =====================================================================
	// pull sequencer
	logic [7:0] left_r;
	logic gap_r;
	// busy while pulls remain or one is on the wire
	assign o_busy = (left_r != 8'h00) || o_hs_rdy;
	// slow mode leaves an idle cycle between pulls
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			left_r <= 8'h00;
			gap_r <= 1'b0;
			o_hs_rdy <= 1'b0;
			o_last <= 10'h000;
		end else begin
			if (i_agg_vld) begin
				o_last <= i_agg_data;
			end
			if (i_start) begin
				left_r <= i_count;
				o_hs_rdy <= 1'b0;
				gap_r <= 1'b0;
			end else if (left_r != 8'h00 && !(i_slow && gap_r)) begin
				o_hs_rdy <= 1'b1;
				left_r <= left_r - 8'h01;
				gap_r <= 1'b1;
			end else begin
				o_hs_rdy <= 1'b0;
				gap_r <= 1'b0;
			end
		end
	end
endmodule // lit_far_rx

// *** src/lit_pkg.sv ***
// lit_pkg.sv - types shared by the lane interleave transmit path
// assumes nothing beyond the register header
package lit_pkg;
	typedef logic [9:0] lit_char_t;
	typedef enum logic [1:0] {LIT_WORD = 2'h1, LIT_BIT = 2'h2} lit_mode_t;
	typedef enum logic [1:0] {LIT_ENC_FIRST = 2'h1, LIT_SCR_FIRST = 2'h2} lit_order_t;
endpackage

// *** src/lit_regs.svh ***
// lit_regs.svh - register offsets, field positions, reset values and constants
// assumes a 32-bit classic wishbone slave, one aligned word per register
// Function
// - each channel merges two, three or four lane streams into one aggregate stream.
// - each lane can find 10-bit word boundaries from a programmed pattern, or pass unaligned.
// - each lane can 8b/10b decode its aligned words, and both stages can be bypassed.
// - each lane is written into its own fifo that the aggregate side reads.
// - when enabled each lane fifo also compensates small rate mismatch.
// - aggregation offers exactly word interleaving or bit interleaving, chosen by config.
// - word interleaving takes 10 bits from each lane in round-robin turn.
// - bit interleaving takes one bit from each lane in turn.
// - the aggregate stream can be 8b/10b encoded under config control.
// - the aggregate stream can be scrambled by a polynomial scrambler.
// - with both on, config picks encode-then-scramble or scramble-then-encode.
// - in scramble-then-encode order control characters skip the scrambler.
// - each lane replaces a programmable search character by a replacement character.
`ifndef LIT_REGS_SVH
`define LIT_REGS_SVH

// =====================================================================
// register offsets
`define LIT_CTRL_OFS 8'h00
`define LIT_ALIGN_OFS 8'h04
`define LIT_MARK_OFS 8'h08
`define LIT_IDLE_OFS 8'h0C
`define LIT_STAT_OFS 8'h10

// =====================================================================
// control fields and reset values
`define LIT_F_DPRST 0
`define LIT_F_MODE 1
`define LIT_F_ENC 2
`define LIT_F_SCR 3
`define LIT_F_ORDER 4
`define LIT_F_NL 5
`define LIT_F_ALIGN 7
`define LIT_F_DEC 8
`define LIT_F_CTC 9
`define LIT_F_MARK 10
`define LIT_CTRL_RST 11'h001
`define LIT_ALIGN_RST 10'h17C
`define LIT_IDLE_RST 10'h0BC
`define LIT_SRCH_RST 10'h11C
`define LIT_REPL_RST 10'h1FC

// =====================================================================
// coding constants
`define LIT_K28_6B 6'h0F
`define LIT_SCR_TAP_A 38
`define LIT_SCR_TAP_B 57

`endif

// *** src/lit_tx_path.sv ***
// lit_tx_path.sv - transmit datapath of one aggregation channel
// assumes lane words arrive deserialised and synchronous to i_core_clk,
// and the serialiser pulls one aggregate word on each i_hs_rdy
`timescale 1ns/1ps
`include "lit_regs.svh"
module lit_tx_path #(
	parameter int NL = 4,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	input wire logic [NL-1:0] i_lane_vld,
	input wire logic [NL*10-1:0] i_lane_data,
	input wire logic i_hs_rdy,
	output lit_pkg::lit_char_t o_agg_data,
	output logic o_agg_vld
);
	import lit_pkg::*;

	// =====================================================================
	// coding tables and functions
	localparam logic [5:0] T6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	// 5b/6b sub-block at running disparity rd
	function automatic logic [5:0] enc6(input logic [4:0] x, input logic k, input logic rd);
		logic [5:0] b;
		b = (k && x == 5'h1C) ? `LIT_K28_6B : T6[x];
		if (rd && ($countones(b) != 3 || b == 6'h38))
			b = ~b;
		return b;
	endfunction

	// 3b/4b sub-block, alternate code where a run of five must be avoided
	function automatic logic [3:0] enc4(input logic [2:0] y, input logic [4:0] x,
		input logic k, input logic rd);
		logic [3:0] b;
		logic alt;
		alt = (y == 3'h7) && (k || (!rd && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
		b = alt ? 4'h7 : T4[y];
		if (rd && ($countones(b) != 2 || b == 4'hC))
			b = ~b;
		// control forms of the balanced codes flip at negative disparity
		if (k && !rd && $countones(b) == 2 && b != 4'hC)
			b = ~b;
		return b;
	endfunction

	// {k, data} to {new rd, code}
	function automatic logic [10:0] enc10(input logic [8:0] c, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic r;
		s6 = enc6(c[4:0], c[8], rd);
		r = rd ^ ($countones(s6) != 3);
		s4 = enc4(c[7:5], c[4:0], c[8], r);
		r = r ^ ($countones(s4) != 2);
		return {r, s6, s4};
	endfunction

	// code to {error, k, data}
	function automatic logic [9:0] dec10(input logic [9:0] w);
		logic [3:0] f;
		logic [4:0] x;
		logic [2:0] y;
		logic k;
		logic h6;
		logic h4;
		x = 5'h00;
		y = 3'h0;
		h6 = 1'b0;
		h4 = 1'b0;
		k = (w[9:4] == `LIT_K28_6B) || (w[9:4] == ~`LIT_K28_6B);
		f = (w[9:4] == ~`LIT_K28_6B) ? ~w[3:0] : w[3:0];
		for (int i = 0; i < 32; i++) begin
			if (w[9:4] == enc6(5'(i), 1'b0, 1'b0) || w[9:4] == enc6(5'(i), 1'b0, 1'b1)) begin
				x = 5'(i);
				h6 = 1'b1;
			end
		end
		if (k) begin
			x = 5'h1C;
			h6 = 1'b1;
		end
		for (int i = 0; i < 8; i++) begin
			if (f == enc4(3'(i), 5'h00, 1'b0, 1'b0) || f == enc4(3'(i), 5'h00, 1'b0, 1'b1)) begin
				y = 3'(i);
				h4 = 1'b1;
			end
		end
		if (f == 4'h7 || f == 4'h8) begin
			y = 3'h7;
			h4 = 1'b1;
			k = k || x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E;
		end
		return {!(h6 && h4), k, y, x};
	endfunction

	// self-synchronising scrambler over the low n bits, msb first
	function automatic logic [67:0] scr(input logic [57:0] s, input logic [9:0] d, input int n);
		logic [9:0] o;
		logic b;
		o = d;
		for (int i = 9; i >= 0; i--) begin
			if (i < n) begin
				b = d[i] ^ s[`LIT_SCR_TAP_A] ^ s[`LIT_SCR_TAP_B];
				o[i] = b;
				s = {s[56:0], b};
			end
		end
		return {s, o};
	endfunction

	// bit j of the result is bit j/n of lane j%n
	function automatic logic [NL*10-1:0] ilv(input logic [NL*10-1:0] w, input int n);
		logic [NL*10-1:0] o;
		o = '0;
		for (int j = 0; j < NL*10; j++) begin
			if (j < n*10)
				o[j] = w[(j % n)*10 + j / n];
		end
		return o;
	endfunction

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] bsel(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				o[b*8 +: 8] = n[b*8 +: 8];
		end
		return o;
	endfunction

	// =====================================================================
	// register file and status
	logic [10:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt;
	logic [9:0] apat_r, apat_nxt, srch_r, srch_nxt, repl_r, repl_nxt, idle_r, idle_nxt;
	logic [NL-1:0] ovf_r, ovf_nxt, und_r, und_nxt, err_r, err_nxt, pop, und_set;
	logic ack_r, ack_nxt, hit;
	logic [31:0] rdat_r, rdat_nxt, wv32;
	wire [NL-1:0] lock_v, ovf_w, err_w, emp_w, und_w;
	wire [NL*10-1:0] tk_w;
	logic dp;
	logic [2:0] nl_c;
	lit_mode_t mode_c;
	lit_order_t order_c;

	assign dp = ctrl_r[`LIT_F_DPRST];
	assign nl_c = (cfg_r[`LIT_F_NL +: 2] == 2'h0) ? 3'h2 :
		(cfg_r[`LIT_F_NL +: 2] == 2'h1) ? 3'h3 : 3'h4;
	assign mode_c = cfg_r[`LIT_F_MODE] ? LIT_BIT : LIT_WORD;
	assign order_c = cfg_r[`LIT_F_ORDER] ? LIT_SCR_FIRST : LIT_ENC_FIRST;

	// bus decode, register writes, sticky flags
	always_comb begin
		hit = i_wb_cyc && i_wb_stb && !ack_r;
		ack_nxt = hit;
		rdat_nxt = rdat_r;
		ctrl_nxt = ctrl_r;
		apat_nxt = apat_r;
		srch_nxt = srch_r;
		repl_nxt = repl_r;
		idle_nxt = idle_r;
		ovf_nxt = ovf_r;
		und_nxt = und_r;
		err_nxt = err_r;
		wv32 = 32'h0000_0000;
		if (hit) begin
			unique case (i_wb_adr)
				`LIT_CTRL_OFS: begin
					rdat_nxt = {21'h000000, ctrl_r};
					wv32 = bsel({21'h000000, ctrl_r}, i_wb_dat, i_wb_sel);
					if (i_wb_we)
						ctrl_nxt = wv32[10:0];
				end
				`LIT_ALIGN_OFS: begin
					rdat_nxt = {22'h000000, apat_r};
					wv32 = bsel({22'h000000, apat_r}, i_wb_dat, i_wb_sel);
					if (i_wb_we)
						apat_nxt = wv32[9:0];
				end
				`LIT_MARK_OFS: begin
					rdat_nxt = {6'h00, repl_r, 6'h00, srch_r};
					wv32 = bsel(rdat_nxt, i_wb_dat, i_wb_sel);
					if (i_wb_we) begin
						srch_nxt = wv32[9:0];
						repl_nxt = wv32[25:16];
					end
				end
				`LIT_IDLE_OFS: begin
					rdat_nxt = {22'h000000, idle_r};
					wv32 = bsel({22'h000000, idle_r}, i_wb_dat, i_wb_sel);
					if (i_wb_we)
						idle_nxt = wv32[9:0];
				end
				`LIT_STAT_OFS: begin
					rdat_nxt = 32'({err_r, und_r, ovf_r, lock_v});
					if (i_wb_we) begin
						wv32 = i_wb_dat >> NL;
						ovf_nxt = ovf_r & ~wv32[NL-1:0];
						wv32 = i_wb_dat >> (2*NL);
						und_nxt = und_r & ~wv32[NL-1:0];
						wv32 = i_wb_dat >> (3*NL);
						err_nxt = err_r & ~wv32[NL-1:0];
					end
				end
				default: rdat_nxt = 32'h0000_0000;
			endcase
		end
		if (dp) begin
			ovf_nxt = '0;
			und_nxt = '0;
			err_nxt = '0;
		end
		ovf_nxt = ovf_nxt | ovf_w;
		und_nxt = und_nxt | und_set;
		err_nxt = err_nxt | err_w;
		cfg_nxt = dp ? ctrl_r : cfg_r;
	end

	// register the bus group
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ctrl_r <= `LIT_CTRL_RST;
			cfg_r <= `LIT_CTRL_RST;
			apat_r <= `LIT_ALIGN_RST;
			srch_r <= `LIT_SRCH_RST;
			repl_r <= `LIT_REPL_RST;
			idle_r <= `LIT_IDLE_RST;
			ovf_r <= '0;
			und_r <= '0;
			err_r <= '0;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else if (i_ce) begin
			ctrl_r <= ctrl_nxt;
			cfg_r <= cfg_nxt;
			apat_r <= apat_nxt;
			srch_r <= srch_nxt;
			repl_r <= repl_nxt;
			idle_r <= idle_nxt;
			ovf_r <= ovf_nxt;
			und_r <= und_nxt;
			err_r <= err_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end
	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;

	// =====================================================================
	// lanes: align, decode, mark, fifo
	logic [9:0] mem_r [NL][DEPTH];
	logic [9:0] mem_nxt [NL][DEPTH];
	logic [9:0] prev_r [NL];
	logic [9:0] prev_nxt [NL];
	logic [3:0] ofs_r [NL];
	logic [3:0] ofs_nxt [NL];
	logic [AW-1:0] wp_r [NL];
	logic [AW-1:0] wp_nxt [NL];
	logic [AW-1:0] rp_r [NL];
	logic [AW-1:0] rp_nxt [NL];
	logic [AW:0] cnt_r [NL];
	logic [AW:0] cnt_nxt [NL];
	logic lock_r [NL];
	logic lock_nxt [NL];
	logic lidl_r [NL];
	logic lidl_nxt [NL];

	for (genvar l = 0; l < NL; l++) begin : g_lane
		logic [19:0] cat;
		logic [9:0] w, wd, d;
		logic [3:0] mofs;
		logic match, wv, del, wr, full;
		assign lock_v[l] = lock_r[l];
		assign emp_w[l] = (cnt_r[l] == '0);
		assign tk_w[l*10 +: 10] = emp_w[l] ? idle_r : mem_r[l][rp_r[l]];
		assign und_w[l] = emp_w[l] && !(cfg_r[`LIT_F_CTC] && lidl_r[l]);
		assign ovf_w[l] = wv && !del && full;
		assign err_w[l] = wv && cfg_r[`LIT_F_DEC] && d[9];

		// one lane word in, one fifo entry out
		always_comb begin
			cat = {prev_r[l], i_lane_data[l*10 +: 10]};
			prev_nxt[l] = prev_r[l];
			ofs_nxt[l] = ofs_r[l];
			lock_nxt[l] = lock_r[l];
			mem_nxt[l] = mem_r[l];
			match = 1'b0;
			mofs = 4'h0;
			for (int o = 9; o >= 0; o--) begin
				if (cat[19-o -: 10] == apat_r || cat[19-o -: 10] == ~apat_r) begin
					match = 1'b1;
					mofs = 4'(o);
				end
			end
			wv = 1'b0;
			w = i_lane_data[l*10 +: 10];
			if (i_lane_vld[l]) begin
				prev_nxt[l] = i_lane_data[l*10 +: 10];
				if (!cfg_r[`LIT_F_ALIGN]) begin
					wv = 1'b1;
				end else if (lock_r[l]) begin
					wv = 1'b1;
					w = cat[19-ofs_r[l] -: 10];
				end else if (match) begin
					lock_nxt[l] = 1'b1;
					ofs_nxt[l] = mofs;
					wv = 1'b1;
					w = cat[19-mofs -: 10];
				end
			end
			d = dec10(w);
			wd = cfg_r[`LIT_F_DEC] ? {1'b0, d[8:0]} : w;
			if (cfg_r[`LIT_F_MARK] && wd == srch_r)
				wd = repl_r;
			full = (cnt_r[l] == (AW+1)'(DEPTH));
			del = cfg_r[`LIT_F_CTC] && wd == idle_r && cnt_r[l] >= (AW+1)'(DEPTH/2);
			wr = wv && !del && !full;
			if (wr)
				mem_nxt[l][wp_r[l]] = wd;
			wp_nxt[l] = wr ? wp_r[l] + 1'b1 : wp_r[l];
			rp_nxt[l] = pop[l] ? rp_r[l] + 1'b1 : rp_r[l];
			cnt_nxt[l] = cnt_r[l] + (AW+1)'(wr) - (AW+1)'(pop[l]);
			lidl_nxt[l] = pop[l] ? (tk_w[l*10 +: 10] == idle_r) : lidl_r[l];
			if (dp) begin
				lock_nxt[l] = 1'b0;
				wp_nxt[l] = '0;
				rp_nxt[l] = '0;
				cnt_nxt[l] = '0;
				lidl_nxt[l] = 1'b0;
			end
		end

		// register the lane group
		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				prev_r[l] <= 10'h000;
				ofs_r[l] <= 4'h0;
				lock_r[l] <= 1'b0;
				wp_r[l] <= '0;
				rp_r[l] <= '0;
				cnt_r[l] <= '0;
				lidl_r[l] <= 1'b0;
			end else if (i_ce) begin
				prev_r[l] <= prev_nxt[l];
				ofs_r[l] <= ofs_nxt[l];
				lock_r[l] <= lock_nxt[l];
				wp_r[l] <= wp_nxt[l];
				rp_r[l] <= rp_nxt[l];
				cnt_r[l] <= cnt_nxt[l];
				lidl_r[l] <= lidl_nxt[l];
			end
		end

		// fifo storage
		always_ff @(posedge i_core_clk) begin
			if (i_ce)
				mem_r[l] <= mem_nxt[l];
		end
	end

	// =====================================================================
	// aggregation, encoding and scrambling
	logic [1:0] rr_r, rr_nxt, left_r, left_nxt;
	logic [NL*10-1:0] bi_r, bi_nxt, full_w;
	logic [57:0] scr_r, scr_nxt;
	logic rd_r, rd_nxt, go, vld_nxt, enc_on, scr_on, sfirst;
	logic [9:0] ch, out, agg_nxt;
	logic [8:0] c9;
	logic [67:0] sv;
	logic [10:0] ev;

	// pick the next aggregate character and code it
	always_comb begin
		go = i_hs_rdy;
		rr_nxt = rr_r;
		left_nxt = left_r;
		bi_nxt = bi_r;
		pop = '0;
		und_set = '0;
		ch = idle_r;
		full_w = ilv(tk_w, int'(nl_c));
		if (go && mode_c == LIT_WORD) begin
			ch = tk_w[rr_r*10 +: 10];
			pop[rr_r] = !emp_w[rr_r];
			und_set[rr_r] = und_w[rr_r];
			rr_nxt = (rr_r == 2'(nl_c - 3'h1)) ? 2'h0 : rr_r + 2'h1;
		end else if (go && left_r == 2'h0) begin
			for (int l = 0; l < NL; l++) begin
				pop[l] = (l < nl_c) && !emp_w[l];
				und_set[l] = (l < nl_c) && und_w[l];
			end
			ch = full_w[9:0];
			bi_nxt = full_w >> 10;
			left_nxt = 2'(nl_c - 3'h1);
		end else if (go) begin
			ch = bi_r[9:0];
			bi_nxt = bi_r >> 10;
			left_nxt = left_r - 2'h1;
		end
		enc_on = cfg_r[`LIT_F_ENC];
		scr_on = cfg_r[`LIT_F_SCR];
		sfirst = enc_on && order_c == LIT_SCR_FIRST;
		c9 = (mode_c == LIT_BIT) ? {1'b0, ch[7:0]} : ch[8:0];
		out = ch;
		rd_nxt = rd_r;
		scr_nxt = scr_r;
		sv = {scr_r, 1'b0, c9};
		if (scr_on && sfirst && !c9[8])
			sv = scr(scr_r, {1'b0, c9}, 8);
		ev = enc10(sv[8:0], rd_r);
		if (enc_on) begin
			out = ev[9:0];
			rd_nxt = ev[10];
		end
		if (scr_on && !sfirst) begin
			sv = scr(scr_r, out, 10);
			out = sv[9:0];
		end
		if (scr_on)
			scr_nxt = sv[67:10];
		agg_nxt = go ? out : o_agg_data;
		vld_nxt = go;
		if (!go) begin
			rd_nxt = rd_r;
			scr_nxt = scr_r;
		end
		if (dp) begin
			rr_nxt = 2'h0;
			left_nxt = 2'h0;
			rd_nxt = 1'b0;
			scr_nxt = '0;
			vld_nxt = 1'b0;
			pop = '0;
			und_set = '0;
		end
	end

	// register the aggregate group
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rr_r <= 2'h0;
			left_r <= 2'h0;
			bi_r <= '0;
			scr_r <= '0;
			rd_r <= 1'b0;
			o_agg_data <= 10'h000;
			o_agg_vld <= 1'b0;
		end else if (i_ce) begin
			rr_r <= rr_nxt;
			left_r <= left_nxt;
			bi_r <= bi_nxt;
			scr_r <= scr_nxt;
			rd_r <= rd_nxt;
			o_agg_data <= agg_nxt;
			o_agg_vld <= vld_nxt;
		end
	end

	// =====================================================================
	// assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n || !i_ce);

	sequence bus_req_s;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence bus_ack_s;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
		else $error("bus request not answered in one cycle");
	cfg_frozen_a: assert property (!dp |=> $stable(cfg_r))
		else $error("config changed outside datapath reset");
	word_turn_a: assert property (go && !dp && mode_c == LIT_WORD |=>
		rr_r == (($past(rr_r) == 2'($past(nl_c) - 3'h1)) ? 2'h0 : $past(rr_r) + 2'h1))
		else $error("word turn did not advance round robin");
	bit_left_a: assert property (mode_c == LIT_BIT |-> left_r < nl_c)
		else $error("bit interleave count beyond lane count");
	agg_valid_a: assert property (go && !dp |=> o_agg_vld)
		else $error("aggregate word missing after request");
	align_lock_a: assert property (lock_v[0] |-> cfg_r[`LIT_F_ALIGN])
		else $error("lane locked with alignment off");
	scr_bypass_a: assert property (go && !dp && scr_on && sfirst && c9[8]
		|=> $stable(scr_r))
		else $error("control character entered scrambler");
	enc_rd_a: assert property (go && !dp && !enc_on |=> $stable(rd_r))
		else $error("disparity moved with encoder off");
	ovf_keep_a: assert property (ovf_r[0] && !dp && !(hit && i_wb_we) |=> ovf_r[0])
		else $error("overflow flag lost");
endmodule // lit_tx_path
